// ### core/operand_shifter_pkg.sv
// shared types and constants for the flexible second operand datapath
// assumes a 32-bit core where decode and register read share one clock
package operand_shifter_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned IMM_BYTE_W = 8;
  localparam int unsigned IMM_SHIFT_W = 5;
  localparam int unsigned SHIFT_AMT_W = 8;

  // ==========================================================================
  // immediate limits and shift length bounds
  localparam logic [31:0] IMM_PLAIN_MAX = 32'h0000_00FF;
  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_WORD = 8'h20;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONES = 32'hFFFF_FFFF;

  // ==========================================================================
  // reset values of the result stage
  localparam logic [31:0] OPERAND_RST = 32'h0000_0000;
  localparam logic CARRY_RST = 1'b0;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    imm_shifted,
    imm_rep_low,
    imm_rep_high,
    imm_rep_all
  } imm_kind_t;

  typedef enum logic [2:0] {
    shift_none,
    logical_shift_left,
    logical_shift_right,
    arith_shift_right,
    rotate_right,
    rotate_through_carry
  } shift_kind_t;

  typedef enum logic [2:0] {
    acc_byte,
    acc_half,
    acc_word,
    acc_dword,
    acc_multi
  } acc_size_t;

  typedef enum logic [3:0] {
    load_word,
    load_word_unpriv,
    load_half,
    load_half_unpriv,
    load_signed_half,
    load_signed_half_unpriv,
    store_word,
    store_word_unpriv,
    store_half,
    store_half_unpriv,
    mem_other
  } mem_op_t;

endpackage

// ### core/align_checker.sv
// address alignment checker for one load or store access
// assumes size and instruction class come decoded from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module align_checker
  import operand_shifter_pkg::*;
(
  input wire acc_size_t acc_size_in,
  input wire mem_op_t mem_op_in,
  input wire logic [1:0] addr_low_in,
  input wire logic misalign_trap_enable_in,
  output logic misaligned_out,
  output logic usage_fault_out
);

  logic unaligned_permitted;

  // ==========================================================================
  // alignment by access size
  always_comb begin
    misaligned_out = 1'b0;
    if (acc_size_in == acc_half) begin
      misaligned_out = addr_low_in[0];
    end else if (acc_size_in == acc_word || acc_size_in == acc_dword || acc_size_in == acc_multi) begin
      misaligned_out = (addr_low_in != 2'h0);
    end
  end

  // ==========================================================================
  // only the single word and halfword forms may run unaligned
  always_comb begin
    unaligned_permitted = 1'b0;
    if (mem_op_in != mem_other) begin
      unaligned_permitted = 1'b1;
    end
  end

  // trap enable overrides the permitted list
  assign usage_fault_out = misaligned_out && (!unaligned_permitted || misalign_trap_enable_in);

endmodule
`default_nettype wire

// ### core/operand_shifter.sv
// flexible second operand builder with carry-out and access alignment check
// assumes decoder, register file and status flags run on sys_clk_in
// Function
// - expand byte shifted or replicated into constant
// - shifted immediate above 255 loads carry from bit 31
// - accept documented shift kinds and lengths
// - no shift passes source unchanged
// - shifted value feeds operand only
// - zero length keeps value and carry
// - arithmetic right fills with sign bit
// - arithmetic carry bit n-1, wide gives sign
// - logical right zero fill, wide gives zero
// - left shift carry from bit 32-n
// - rotate wraps, length 32 keeps source
// - rotate through carry by one
// - branch target bit zero must be set
// - alignment by word, halfword, byte size
// - unaligned allowed for single word, halfword
// - other unaligned accesses raise usage fault
// - trap enable faults every unaligned access
`timescale 1ns/100ps
`default_nettype none
module operand_shifter
  import operand_shifter_pkg::*;
#(
  parameter int unsigned AMT_W = SHIFT_AMT_W
)(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // operand request
  input wire logic op_valid_in,
  input wire logic use_imm_in,
  input wire imm_kind_t imm_kind_in,
  input wire logic [IMM_BYTE_W-1:0] imm_byte_in,
  input wire logic [IMM_SHIFT_W-1:0] imm_shift_in,
  input wire logic [WORD_W-1:0] shift_source_register_in,
  input wire shift_kind_t shift_kind_in,
  input wire logic [AMT_W-1:0] shift_amt_in,
  input wire logic set_flags_in,
  input wire logic carry_flag_in,
  // memory access and branch target check
  input wire logic mem_valid_in,
  input wire acc_size_t acc_size_in,
  input wire mem_op_t mem_op_in,
  input wire logic [WORD_W-1:0] mem_addr_in,
  input wire logic misalign_trap_enable_in,
  input wire logic pc_write_in,
  input wire logic [WORD_W-1:0] pc_target_in,
  // results
  output logic op_valid_out,
  output logic [WORD_W-1:0] flexible_second_operand_out,
  output logic carry_flag_out,
  output logic carry_changed_out,
  output logic check_valid_out,
  output logic misaligned_out,
  output logic usage_fault_out,
  output logic pc_state_fault_out
);

  logic [WORD_W-1:0] imm_value;
  logic imm_carry_hit;
  logic [WORD_W-1:0] shift_value;
  logic shift_carry;
  logic shift_carry_hit;
  logic [WORD_W-1:0] oper_d;
  logic carry_d;
  logic changed_d;
  logic [7:0] amt;
  logic [7:0] amt_m1;
  logic [4:0] rot_amt;
  logic [WORD_W-1:0] right_m1;
  logic [WORD_W-1:0] left_m1;
  logic [2*WORD_W-1:0] rot_pair;
  logic misaligned_d;
  logic align_fault_d;
  logic pc_fault_d;

  // ==========================================================================
  // immediate expansion
  // shift amounts past 24 drop the upper byte bits; decode never asks for them
  always_comb begin
    imm_value = WORD_ZERO;
    case (imm_kind_in)
      imm_shifted: begin
        imm_value = {24'h00_0000, imm_byte_in} << imm_shift_in;
      end
      imm_rep_low: begin
        imm_value = {8'h00, imm_byte_in, 8'h00, imm_byte_in};
      end
      imm_rep_high: begin
        imm_value = {imm_byte_in, 8'h00, imm_byte_in, 8'h00};
      end
      default: begin
        imm_value = {imm_byte_in, imm_byte_in, imm_byte_in, imm_byte_in};
      end
    endcase
  end

  // replicated patterns never touch carry, even when their value is large
  assign imm_carry_hit = (imm_kind_in == imm_shifted) && (imm_value > IMM_PLAIN_MAX);

  // ==========================================================================
  // register shifter
  assign amt = 8'(shift_amt_in);
  assign amt_m1 = amt - LEN_ONE;
  assign rot_amt = amt[4:0];
  assign right_m1 = shift_source_register_in >> amt_m1;
  assign left_m1 = shift_source_register_in << amt_m1;
  assign rot_pair = {shift_source_register_in, shift_source_register_in} >> rot_amt;

  always_comb begin
    shift_value = shift_source_register_in;
    shift_carry = carry_flag_in;
    shift_carry_hit = 1'b0;
    case (shift_kind_in)
      logical_shift_left: begin
        if (amt == LEN_ZERO) begin
          shift_value = shift_source_register_in;
        end else if (amt < LEN_WORD) begin
          shift_value = shift_source_register_in << amt;
          shift_carry = left_m1[WORD_W-1];
          shift_carry_hit = 1'b1;
        end else if (amt == LEN_WORD) begin
          shift_value = WORD_ZERO;
          shift_carry = shift_source_register_in[0];
          shift_carry_hit = 1'b1;
        end else begin
          shift_value = WORD_ZERO;
          shift_carry = 1'b0;
          shift_carry_hit = 1'b1;
        end
      end
      logical_shift_right: begin
        if (amt == LEN_ZERO) begin
          shift_value = shift_source_register_in;
        end else if (amt < LEN_WORD) begin
          shift_value = shift_source_register_in >> amt;
          shift_carry = right_m1[0];
          shift_carry_hit = 1'b1;
        end else if (amt == LEN_WORD) begin
          shift_value = WORD_ZERO;
          shift_carry = shift_source_register_in[WORD_W-1];
          shift_carry_hit = 1'b1;
        end else begin
          shift_value = WORD_ZERO;
          shift_carry = 1'b0;
          shift_carry_hit = 1'b1;
        end
      end
      arith_shift_right: begin
        if (amt == LEN_ZERO) begin
          shift_value = shift_source_register_in;
        end else if (amt < LEN_WORD) begin
          shift_value = $unsigned($signed(shift_source_register_in) >>> amt);
          shift_carry = right_m1[0];
          shift_carry_hit = 1'b1;
        end else begin
          shift_value = shift_source_register_in[WORD_W-1] ? WORD_ONES : WORD_ZERO;
          shift_carry = shift_source_register_in[WORD_W-1];
          shift_carry_hit = 1'b1;
        end
      end
      rotate_right: begin
        if (amt == LEN_ZERO) begin
          shift_value = shift_source_register_in;
        end else if (rot_amt == 5'h00) begin
          // any multiple of 32 lands back on the source
          shift_value = shift_source_register_in;
          shift_carry = shift_source_register_in[WORD_W-1];
          shift_carry_hit = 1'b1;
        end else begin
          shift_value = rot_pair[WORD_W-1:0];
          shift_carry = rot_pair[WORD_W-1];
          shift_carry_hit = 1'b1;
        end
      end
      rotate_through_carry: begin
        shift_value = {carry_flag_in, shift_source_register_in[WORD_W-1:1]};
        shift_carry = shift_source_register_in[0];
        shift_carry_hit = 1'b1;
      end
      default: begin
        shift_value = shift_source_register_in;
      end
    endcase
  end

  // ==========================================================================
  // operand and carry selection
  always_comb begin
    if (use_imm_in) begin
      oper_d = imm_value;
      changed_d = set_flags_in && imm_carry_hit;
      carry_d = changed_d ? imm_value[WORD_W-1] : carry_flag_in;
    end else begin
      oper_d = shift_value;
      changed_d = set_flags_in && shift_carry_hit;
      carry_d = changed_d ? shift_carry : carry_flag_in;
    end
  end

  // the source register is only read here, never written back
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flexible_second_operand_out <= OPERAND_RST;
    end else if (op_valid_in) begin
      flexible_second_operand_out <= oper_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carry_flag_out <= CARRY_RST;
      carry_changed_out <= 1'b0;
    end else if (op_valid_in) begin
      carry_flag_out <= carry_d;
      carry_changed_out <= changed_d;
    end else begin
      carry_changed_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_valid_out <= 1'b0;
    end else begin
      op_valid_out <= op_valid_in;
    end
  end

  // ==========================================================================
  // alignment and branch target checks
  align_checker u_align (
    .acc_size_in(acc_size_in),
    .mem_op_in(mem_op_in),
    .addr_low_in(mem_addr_in[1:0]),
    .misalign_trap_enable_in(misalign_trap_enable_in),
    .misaligned_out(misaligned_d),
    .usage_fault_out(align_fault_d)
  );

  // only the compressed instruction set exists, so bit 0 clear cannot execute
  assign pc_fault_d = pc_write_in && !pc_target_in[0];

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      check_valid_out <= 1'b0;
      misaligned_out <= 1'b0;
      usage_fault_out <= 1'b0;
      pc_state_fault_out <= 1'b0;
    end else begin
      check_valid_out <= mem_valid_in || pc_write_in;
      misaligned_out <= mem_valid_in && misaligned_d;
      usage_fault_out <= (mem_valid_in && align_fault_d) || pc_fault_d;
      pc_state_fault_out <= pc_fault_d;
    end
  end

  // ==========================================================================
  // assertions
  a_pass_through: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && shift_kind_in == shift_none
    |=> flexible_second_operand_out == $past(shift_source_register_in))
    else $error("unshifted operand differs from source");

  a_zero_len_carry: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && shift_kind_in != rotate_through_carry && shift_amt_in == '0
    |=> !carry_changed_out && carry_flag_out == $past(carry_flag_in))
    else $error("zero length shift touched carry");

  a_carry_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !set_flags_in |=> carry_flag_out == $past(carry_flag_in) && !carry_changed_out)
    else $error("carry changed without flag update");

  a_asr_sign_fill: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && set_flags_in && shift_kind_in == arith_shift_right && shift_amt_in >= 32
    |=> flexible_second_operand_out == {32{$past(shift_source_register_in[31])}}
        && carry_flag_out == $past(shift_source_register_in[31]))
    else $error("wide arithmetic shift not sign filled");

  a_lsl_carry: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && set_flags_in && shift_kind_in == logical_shift_left && shift_amt_in == 1
    |=> carry_flag_out == $past(shift_source_register_in[31]) && carry_changed_out)
    else $error("left shift carry not from top bit");

  a_lsr_wide: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && set_flags_in && shift_kind_in == logical_shift_right && shift_amt_in > 32
    |=> flexible_second_operand_out == '0 && !carry_flag_out)
    else $error("wide logical shift not cleared");

  a_rrx_form: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && set_flags_in && shift_kind_in == rotate_through_carry
    |=> flexible_second_operand_out[31] == $past(carry_flag_in)
        && carry_flag_out == $past(shift_source_register_in[0]))
    else $error("rotate through carry wrong");

  a_ror_full: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && shift_kind_in == rotate_right && shift_amt_in == 32
    |=> flexible_second_operand_out == $past(shift_source_register_in))
    else $error("rotate by 32 changed value");

  a_imm_rep_carry: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && use_imm_in && imm_kind_in != imm_shifted |=> !carry_changed_out)
    else $error("replicated constant changed carry");

  a_trap_all: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    mem_valid_in && misalign_trap_enable_in && acc_size_in == acc_word && mem_addr_in[0]
    |=> usage_fault_out && misaligned_out)
    else $error("trap enable missed unaligned access");

  a_multi_fault: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    mem_valid_in && mem_op_in == mem_other && acc_size_in == acc_multi && mem_addr_in[1]
    |=> usage_fault_out)
    else $error("unaligned multiple access not faulted");

  a_half_ok: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    mem_valid_in && !pc_write_in && !misalign_trap_enable_in && mem_op_in == load_half
    |=> !usage_fault_out)
    else $error("permitted halfword load faulted");

  a_pc_bit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    pc_write_in && !pc_target_in[0] |=> pc_state_fault_out && usage_fault_out)
    else $error("even branch target not faulted");

  a_imm_shift_carry: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && use_imm_in && set_flags_in && imm_kind_in == imm_shifted && imm_byte_in == 8'h01
    && imm_shift_in == 5'h1F |=> carry_changed_out && carry_flag_out)
    else $error("shifted constant did not load carry");

  a_rep_all_value: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && use_imm_in && imm_kind_in == imm_rep_all
    |=> flexible_second_operand_out == {4{$past(imm_byte_in)}})
    else $error("replicated constant wrong");

  a_lsr_carry: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && set_flags_in && shift_kind_in == logical_shift_right && shift_amt_in == 1
    |=> carry_flag_out == $past(shift_source_register_in[0]) && carry_changed_out)
    else $error("right shift carry not from bit zero");

  a_asr_top_fill: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    op_valid_in && !use_imm_in && shift_kind_in == arith_shift_right && shift_amt_in == 1
    |=> flexible_second_operand_out[31:30] == {2{$past(shift_source_register_in[31])}})
    else $error("arithmetic shift not sign filled");

  a_byte_aligned: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    mem_valid_in && acc_size_in == acc_byte |=> !misaligned_out)
    else $error("byte access flagged misaligned");

endmodule
`default_nettype wire

// ### testbench/flag_holder_model.sv
// status flag holder standing in for the decoder and flag register of the core
// assumes each result arrives one cycle after its operand request
`timescale 1ns/100ps
`default_nettype none
module flag_holder_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic result_valid_in,
  input wire logic carry_new_in,
  input wire logic preset_en_in,
  input wire logic preset_val_in,
  output logic carry_flag_out
);
  logic carry_q;
  // ==========================================================================
  // flag register
  // the preset wins over a result so the bench can pick the incoming carry
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carry_q <= 1'b0;
    end else if (preset_en_in) begin
      carry_q <= preset_val_in;
    end else if (result_valid_in) begin
      carry_q <= carry_new_in;
    end
  end
  assign carry_flag_out = carry_q;
endmodule
`default_nettype wire

// ### testbench/flexible_operand_shifter_align_check_test.sv
// self-checking bench for the operand shifter and alignment checker
// assumes the flag holder model feeds the carry back to the block
`timescale 1ns/100ps
`default_nettype none
module flexible_operand_shifter_align_check_test;
  import operand_shifter_pkg::*;
  localparam int TIMEOUT_CYCLES = 20000;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic op_valid_in = 1'b0, use_imm_in = 1'b0, set_flags_in = 1'b0, carry_flag_in;
  imm_kind_t imm_kind_in = imm_shifted;
  logic [7:0] imm_byte_in = 8'h00, shift_amt_in = 8'h00;
  logic [4:0] imm_shift_in = 5'h00;
  logic [31:0] shift_source_register_in = 32'h0, mem_addr_in = 32'h0, pc_target_in = 32'h1;
  shift_kind_t shift_kind_in = shift_none;
  logic mem_valid_in = 1'b0, misalign_trap_enable_in = 1'b0, pc_write_in = 1'b0;
  acc_size_t acc_size_in = acc_byte;
  mem_op_t mem_op_in = load_word;
  logic preset_en = 1'b0, preset_val = 1'b0;
  logic op_valid_out, carry_flag_out, carry_changed_out, check_valid_out;
  logic misaligned_out, usage_fault_out, pc_state_fault_out;
  logic [31:0] flexible_second_operand_out;
  int err_count = 0, checks_done = 0, cycle_cnt = 0;

  operand_shifter u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid_in),
    .use_imm_in(use_imm_in), .imm_kind_in(imm_kind_in), .imm_byte_in(imm_byte_in), .imm_shift_in(imm_shift_in),
    .shift_source_register_in(shift_source_register_in), .shift_kind_in(shift_kind_in),
    .shift_amt_in(shift_amt_in), .set_flags_in(set_flags_in), .carry_flag_in(carry_flag_in),
    .mem_valid_in(mem_valid_in), .acc_size_in(acc_size_in), .mem_op_in(mem_op_in), .mem_addr_in(mem_addr_in),
    .misalign_trap_enable_in(misalign_trap_enable_in), .pc_write_in(pc_write_in), .pc_target_in(pc_target_in),
    .op_valid_out(op_valid_out), .flexible_second_operand_out(flexible_second_operand_out),
    .carry_flag_out(carry_flag_out), .carry_changed_out(carry_changed_out), .check_valid_out(check_valid_out),
    .misaligned_out(misaligned_out), .usage_fault_out(usage_fault_out), .pc_state_fault_out(pc_state_fault_out));
  flag_holder_model u_flags (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .result_valid_in(op_valid_out),
    .carry_new_in(carry_flag_out), .preset_en_in(preset_en), .preset_val_in(preset_val),
    .carry_flag_out(carry_flag_in));

  // ==========================================================================
  // clock, hang guard and common tasks
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycle_cnt++;
    if (cycle_cnt == TIMEOUT_CYCLES) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic set_carry(input logic c);
    preset_val = c;
    preset_en = 1'b1;
    @(posedge sys_clk_in);
    #1 preset_en = 1'b0;
  endtask

  // e holds changed flag, carry and operand as worked out by the bench
  task automatic fire_op(input logic [33:0] e);
    op_valid_in = 1'b1;
    @(posedge sys_clk_in);
    #1 op_valid_in = 1'b0;
    chk("op valid", 32'h1, {31'h0, op_valid_out});
    chk("operand", e[31:0], flexible_second_operand_out);
    chk("carry", {31'h0, e[32]}, {31'h0, carry_flag_out});
    chk("carry changed", {31'h0, e[33]}, {31'h0, carry_changed_out});
    @(posedge sys_clk_in);
    #1 chk("op valid pulse", 32'h0, {31'h0, op_valid_out});
  endtask

  // reference of one register shift: {changed, carry, value}
  function automatic logic [33:0] ref_op(input shift_kind_t k, input logic [31:0] s, input int n,
                                         input logic c, input logic sf);
    logic [31:0] v;
    logic co;
    logic upd;
    int r;
    v = s;
    co = c;
    r = n % 32;
    upd = (n != 0) && (k != shift_none);
    if (upd) begin
      case (k)
        logical_shift_left: begin
          v = (n >= 32) ? 32'h0 : s << n;
          co = (n > 32) ? 1'b0 : ((n == 32) ? s[0] : s[32-n]);
        end
        logical_shift_right: begin
          v = (n >= 32) ? 32'h0 : s >> n;
          co = (n > 32) ? 1'b0 : s[n-1];
        end
        arith_shift_right: begin
          v = (n >= 32) ? {32{s[31]}} : 32'($signed(s) >>> n);
          co = (n >= 32) ? s[31] : s[n-1];
        end
        rotate_right: begin
          v = (s >> r) | (s << (32 - r));
          co = (r == 0) ? s[31] : s[r-1];
        end
        default: begin
          upd = 1'b0;
        end
      endcase
    end
    if (k == rotate_through_carry) begin
      v = {c, s[31:1]};
      co = s[0];
      upd = 1'b1;
    end
    return {sf & upd, (sf & upd) ? co : c, v};
  endfunction

  // ==========================================================================
  // scenarios
  task automatic test_reset();
    chk("outputs after reset", 32'h0, {op_valid_out, carry_flag_out, carry_changed_out, check_valid_out,
        misaligned_out, usage_fault_out, pc_state_fault_out, flexible_second_operand_out[24:0]});
  endtask

  task automatic test_immediate();
    logic [7:0] bytes [3] = '{8'hA5, 8'h01, 8'hFF};
    int shs [6] = '{0, 1, 7, 8, 24, 31};
    logic [31:0] v;
    logic chg;
    use_imm_in = 1'b1;
    for (int k = 0; k < 4; k++)
      for (int b = 0; b < 3; b++)
        for (int i = 0; i < 12; i++) begin
          set_carry(i[0]);
          imm_kind_in = imm_kind_t'(k);
          imm_byte_in = bytes[b];
          imm_shift_in = shs[i/2][4:0];
          set_flags_in = ~i[0];
          case (imm_kind_in)
            imm_shifted: v = {24'h0, bytes[b]} << shs[i/2];
            imm_rep_low: v = {8'h00, bytes[b], 8'h00, bytes[b]};
            imm_rep_high: v = {bytes[b], 8'h00, bytes[b], 8'h00};
            default: v = {4{bytes[b]}};
          endcase
          chg = set_flags_in && (imm_kind_in == imm_shifted) && (v > 32'h0000_00FF);
          fire_op({chg, chg ? v[31] : i[0], v});
        end
  endtask

  task automatic test_shifts();
    int amts [8] = '{0, 1, 5, 31, 32, 33, 40, 64};
    logic [31:0] srcs [2] = '{32'h8000_0001, 32'h7FFF_FFFE};
    logic [33:0] e;
    use_imm_in = 1'b0;
    for (int k = 0; k < 6; k++)
      for (int a = 0; a < 8; a++)
        for (int i = 0; i < 8; i++) begin
          set_carry(i[0]);
          shift_kind_in = shift_kind_t'(k);
          shift_source_register_in = srcs[i[2]];
          shift_amt_in = amts[a][7:0];
          set_flags_in = i[1];
          e = ref_op(shift_kind_in, srcs[i[2]], amts[a], i[0], i[1]);
          fire_op(e);
          // a new source value with no request must not reach the operand
          shift_source_register_in = ~srcs[i[2]];
          @(posedge sys_clk_in);
          #1 chk("operand held", e[31:0], flexible_second_operand_out);
        end
  endtask

  task automatic test_align();
    logic mis;
    logic flt;
    mem_valid_in = 1'b1;
    for (int o = 0; o < 11; o++)
      for (int s = 0; s < 5; s++)
        for (int i = 0; i < 8; i++) begin
          mem_op_in = mem_op_t'(o);
          acc_size_in = acc_size_t'(s);
          mem_addr_in = 32'h2000_0100 | 32'(i % 4);
          misalign_trap_enable_in = i[2];
          mis = (acc_size_in == acc_half) ? i[0] : (acc_size_in != acc_byte) && (i[1:0] != 2'h0);
          flt = mis && ((mem_op_in == mem_other) || i[2]);
          @(posedge sys_clk_in);
          #1 chk("check valid", 32'h1, {31'h0, check_valid_out});
          chk("misaligned", {31'h0, mis}, {31'h0, misaligned_out});
          chk("usage fault", {31'h0, flt}, {31'h0, usage_fault_out});
        end
    mem_valid_in = 1'b0;
  endtask

  task automatic test_pc();
    pc_write_in = 1'b1;
    for (int i = 0; i < 2; i++) begin
      pc_target_in = 32'h0800_0100 | 32'(i);
      @(posedge sys_clk_in);
      #1 chk("pc check valid", 32'h1, {31'h0, check_valid_out});
      chk("pc fault", {31'h0, ~i[0]}, {31'h0, pc_state_fault_out});
      chk("pc usage fault", {31'h0, ~i[0]}, {31'h0, usage_fault_out});
    end
    pc_write_in = 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    test_reset();
    test_immediate();
    test_shifts();
    test_align();
    test_pc();
    test_done();
  end
endmodule
`default_nettype wire
